/* logic/gph_pkg.sv */
// Constants and types for the port E to H parallel I/O block
// Functional notes
// - Direction 1 drives pin, 0 floats it
// - Reset clears all port E direction bits
// - Reset clears port F direction bits
// - Reset clears port G direction bits
// - Port F latches survive reset
// - Port G latches survive reset
// - Port H latches survive reset
// - Port E output bit reads latch
// - Port E input bit reads pin level
// - Port F read source follows direction
// - Port G read source follows direction
// - Latch writes accepted whatever the direction
// - Direction always read/write; data bits uniform
// - Port F has seven pins, six shareable
// - Port F 0-3 become timer A channels 0-3
// - Port F 4-5 become timer B channels 0-1
// - Timer-owned port F pin ignores direction driver
// - Direction still selects port F read source
// - Port G three pins share keypad inputs
// - Keypad enable forces port G pin input
// - Port H two pins, keypad bits 3-4
// - Peripheral-owned port E pin ignores direction driver
package gph_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int E_W = 8;
  localparam int F_W = 7;
  localparam int G_W = 3;
  localparam int H_W = 2;
  localparam int KBD_W = 5;
  localparam int TA_CH = 4;
  localparam int TB_CH = 2;
  localparam int ELS_W = 2;

  localparam logic [ADDR_W-1:0] PORT_E_DATA_LATCH_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] PORT_F_DATA_LATCH_OFS = 8'h09;
  localparam logic [ADDR_W-1:0] PORT_G_DATA_LATCH_OFS = 8'h0A;
  localparam logic [ADDR_W-1:0] PORT_H_DATA_LATCH_OFS = 8'h0B;
  localparam logic [ADDR_W-1:0] PORT_E_DIRECTION_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] PORT_F_DIRECTION_OFS = 8'h0D;
  localparam logic [ADDR_W-1:0] PORT_G_DIRECTION_OFS = 8'h0E;
  localparam logic [ADDR_W-1:0] PORT_H_DIRECTION_OFS = 8'h0F;

  localparam logic [E_W-1:0] PORT_E_DIRECTION_RST = 8'h00;
  localparam logic [F_W-1:0] PORT_F_DIRECTION_RST = 7'h00;
  localparam logic [G_W-1:0] PORT_G_DIRECTION_RST = 3'h0;
  localparam logic [H_W-1:0] PORT_H_DIRECTION_RST = 2'h0;
  localparam logic [ELS_W-1:0] ELS_GPIO = 2'h0;

  // Port F bit positions of the timer channels
  localparam int TA_F_LSB = 0;
  localparam int TB_F_LSB = 4;
  // Port H keypad enable bits start here
  localparam int KBD_H_LSB = 3;

  typedef struct packed {
    logic [E_W-1:0] e;
    logic [F_W-1:0] f;
    logic [G_W-1:0] g;
    logic [H_W-1:0] h;
  } gph_pins_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } gph_bus_type;

  typedef struct packed {
    logic [E_W-1:0] owner;
    logic [E_W-1:0] out;
    logic [E_W-1:0] oe;
  } gph_periph_e_type;

  typedef struct packed {
    logic [TA_CH*ELS_W-1:0] ta_els;
    logic [TA_CH-1:0] ta_out;
    logic [TA_CH-1:0] ta_oe;
    logic [TB_CH*ELS_W-1:0] tb_els;
    logic [TB_CH-1:0] tb_out;
    logic [TB_CH-1:0] tb_oe;
  } gph_timer_type;

endpackage : gph_pkg

/* logic/gph_ports.sv */
// Port E to H data latches, direction registers, pin drivers and read mux
`timescale 1ns/1ps
module gph_ports
  import gph_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire gph_bus_type bus_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire gph_pins_type pin_in_i,
  output gph_pins_type pin_out_o,
  output gph_pins_type pin_oe_o,
  input wire gph_periph_e_type periph_e_i,
  input wire gph_timer_type timer_i,
  input wire logic [KBD_W-1:0] keypad_interrupt_enable_bits_i,
  output gph_pins_type pin_level_o
);

  logic [E_W-1:0] port_e_data_latch_ff;
  logic [F_W-1:0] port_f_data_latch_ff;
  logic [G_W-1:0] port_g_data_latch_ff;
  logic [H_W-1:0] port_h_data_latch_ff;
  logic [E_W-1:0] port_e_direction_ff;
  logic [F_W-1:0] port_f_direction_ff;
  logic [G_W-1:0] port_g_direction_ff;
  logic [H_W-1:0] port_h_direction_ff;
  gph_pins_type sync1_ff;
  gph_pins_type sync2_ff;
  gph_pins_type pin_out_ff;
  gph_pins_type pin_oe_ff;
  gph_pins_type nxt_pin_out;
  gph_pins_type nxt_pin_oe;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [F_W-1:0] f_owned;
  logic [F_W-1:0] f_tmr_out;
  logic [F_W-1:0] f_tmr_oe;

  // Pins are asynchronous to the system clock
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_in_i;
      sync2_ff <= sync1_ff;
    end
  end

  // Latches have no reset so their contents survive it
  always_ff @(posedge clk_sys_i) begin
    if (bus_i.wr) begin
      case (bus_i.addr)
        PORT_E_DATA_LATCH_OFS: port_e_data_latch_ff <= bus_i.wdata;
        PORT_F_DATA_LATCH_OFS: port_f_data_latch_ff <= bus_i.wdata[F_W-1:0];
        PORT_G_DATA_LATCH_OFS: port_g_data_latch_ff <= bus_i.wdata[G_W-1:0];
        PORT_H_DATA_LATCH_OFS: port_h_data_latch_ff <= bus_i.wdata[H_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_e_direction_ff <= PORT_E_DIRECTION_RST;
      port_f_direction_ff <= PORT_F_DIRECTION_RST;
      port_g_direction_ff <= PORT_G_DIRECTION_RST;
      port_h_direction_ff <= PORT_H_DIRECTION_RST;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        PORT_E_DIRECTION_OFS: port_e_direction_ff <= bus_i.wdata;
        PORT_F_DIRECTION_OFS: port_f_direction_ff <= bus_i.wdata[F_W-1:0];
        PORT_G_DIRECTION_OFS: port_g_direction_ff <= bus_i.wdata[G_W-1:0];
        PORT_H_DIRECTION_OFS: port_h_direction_ff <= bus_i.wdata[H_W-1:0];
        default: ;
      endcase
    end
  end

  // Timer channel takeover of port F, pin 6 stays plain
  generate
    for (genvar i = 0; i < F_W; i++) begin : g_f_own
      if (i >= TA_F_LSB && i < TA_F_LSB + TA_CH) begin : g_ta
        assign f_owned[i] =
          timer_i.ta_els[(i-TA_F_LSB)*ELS_W +: ELS_W] != ELS_GPIO;
        assign f_tmr_out[i] = timer_i.ta_out[i-TA_F_LSB];
        assign f_tmr_oe[i] = timer_i.ta_oe[i-TA_F_LSB];
      end else if (i >= TB_F_LSB && i < TB_F_LSB + TB_CH) begin : g_tb
        assign f_owned[i] =
          timer_i.tb_els[(i-TB_F_LSB)*ELS_W +: ELS_W] != ELS_GPIO;
        assign f_tmr_out[i] = timer_i.tb_out[i-TB_F_LSB];
        assign f_tmr_oe[i] = timer_i.tb_oe[i-TB_F_LSB];
      end else begin : g_gp
        assign f_owned[i] = 1'b0;
        assign f_tmr_out[i] = 1'b0;
        assign f_tmr_oe[i] = 1'b0;
      end
    end
  endgenerate

  always_comb begin
    // Direction drives the buffer unless a peripheral owns the pin
    nxt_pin_oe.e = (periph_e_i.owner & periph_e_i.oe)
                 | (~periph_e_i.owner & port_e_direction_ff);
    nxt_pin_out.e = (periph_e_i.owner & periph_e_i.out)
                  | (~periph_e_i.owner & port_e_data_latch_ff);
    nxt_pin_oe.f = (f_owned & f_tmr_oe) | (~f_owned & port_f_direction_ff);
    nxt_pin_out.f = (f_owned & f_tmr_out) | (~f_owned & port_f_data_latch_ff);
    // Keypad enable forces the pin to an input
    nxt_pin_oe.g = port_g_direction_ff
                 & ~keypad_interrupt_enable_bits_i[G_W-1:0];
    nxt_pin_out.g = port_g_data_latch_ff;
    nxt_pin_oe.h = port_h_direction_ff
                 & ~keypad_interrupt_enable_bits_i[KBD_H_LSB +: H_W];
    nxt_pin_out.h = port_h_data_latch_ff;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // Read source chosen by direction only, even for owned pins
  always_comb begin
    nxt_rdata = '0;
    case (bus_i.addr)
      PORT_E_DATA_LATCH_OFS:
        nxt_rdata = (port_e_direction_ff & port_e_data_latch_ff)
                  | (~port_e_direction_ff & sync2_ff.e);
      PORT_F_DATA_LATCH_OFS:
        nxt_rdata = {1'b0, (port_f_direction_ff & port_f_data_latch_ff)
                  | (~port_f_direction_ff & sync2_ff.f)};
      PORT_G_DATA_LATCH_OFS:
        nxt_rdata = {5'h00, (port_g_direction_ff & port_g_data_latch_ff)
                  | (~port_g_direction_ff & sync2_ff.g)};
      PORT_H_DATA_LATCH_OFS:
        nxt_rdata = {6'h00, (port_h_direction_ff & port_h_data_latch_ff)
                  | (~port_h_direction_ff & sync2_ff.h)};
      PORT_E_DIRECTION_OFS: nxt_rdata = port_e_direction_ff;
      PORT_F_DIRECTION_OFS: nxt_rdata = {1'b0, port_f_direction_ff};
      PORT_G_DIRECTION_OFS: nxt_rdata = {5'h00, port_g_direction_ff};
      PORT_H_DIRECTION_OFS: nxt_rdata = {6'h00, port_h_direction_ff};
      default: nxt_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= '0;
    end else if (bus_i.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_o = rdata_ff;
  assign pin_out_o = pin_out_ff;
  assign pin_oe_o = pin_oe_ff;
  // Synchronised pin levels for the timer and keypad modules
  assign pin_level_o = sync2_ff;

endmodule : gph_ports

/* test/gph_pin_far.sv */
// Far-side pin model for the port E to H block
`timescale 1ns/1ps
module gph_pin_far
  import gph_pkg::*;
(
  input wire gph_pins_type pin_out_i,
  input wire gph_pins_type pin_oe_i,
  input wire gph_pins_type ext_i,
  output gph_pins_type pin_o
);
  // Outside source always drives, so no pin floats to an unknown
  assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule : gph_pin_far

/* test/gph_ports_monitor.sv */
// Assertion checker for the port E to H block
`timescale 1ns/1ps
module gph_ports_mon
  import gph_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire gph_bus_type bus_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire gph_pins_type pin_in_i,
  input wire gph_pins_type pin_out_o,
  input wire gph_pins_type pin_oe_o,
  input wire gph_periph_e_type periph_e_i,
  input wire gph_timer_type timer_i,
  input wire logic [KBD_W-1:0] keypad_interrupt_enable_bits_i,
  input wire gph_pins_type pin_level_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  rst_dir_a: assert property (!$past(reset_n_i) |-> pin_oe_o == '0)
    else $error("drivers on after reset");
  rd_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data without strobe");
  rd_back_a: assert property (bus_i.wr && bus_i.addr == 8'h0C ##1
    bus_i.rd && bus_i.addr == 8'h0C |=> rdata_o == $past(bus_i.wdata, 2))
    else $error("direction readback wrong");
  dir_oe_a: assert property (bus_i.wr && bus_i.addr == 8'h0C && periph_e_i.owner == 8'h00
    ##1 periph_e_i.owner == 8'h00 |=> pin_oe_o.e == $past(bus_i.wdata, 2))
    else $error("direction not on driver");
  own_e_a: assert property (periph_e_i.owner == 8'hFF |=>
    pin_oe_o.e == $past(periph_e_i.oe) && pin_out_o.e == $past(periph_e_i.out))
    else $error("owned port E pin wrong");
  tmr_f_a: assert property (timer_i.ta_els == 8'h55 && timer_i.tb_els == 4'h5 |=>
    pin_oe_o.f[5:0] == {$past(timer_i.tb_oe), $past(timer_i.ta_oe)})
    else $error("timer pin enable wrong");
  kbd_in_a: assert property (keypad_interrupt_enable_bits_i == 5'h1F |=>
    pin_oe_o.g == 3'h0 && pin_oe_o.h == 2'h0)
    else $error("keypad pin driven");
  sync_lvl_a: assert property ($past(reset_n_i) && $past(reset_n_i, 2) |->
    pin_level_o == $past(pin_in_i, 2))
    else $error("pin level delay wrong");
  cover property (bus_i.rd && bus_i.addr == 8'h0A);
  cover property (timer_i.ta_els == 8'h55);
  cover property (keypad_interrupt_enable_bits_i == 5'h1F);
endmodule : gph_ports_mon

bind gph_ports gph_ports_mon u_mon (.clk_sys_i, .reset_n_i, .bus_i, .rdata_o, .pin_in_i,
  .pin_out_o, .pin_oe_o, .periph_e_i, .timer_i, .keypad_interrupt_enable_bits_i, .pin_level_o);

/* test/tb_gph_ports_e_to_h.sv */
// Self-checking bench for the port E to H block
`timescale 1ns/1ps
module tb_gph_ports_e_to_h
  import gph_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  gph_bus_type bus_i = '0;
  gph_pins_type pin_in, pin_out, pin_oe, ext = '0;
  gph_periph_e_type pe = '0;
  gph_timer_type tm = '0;
  logic [KBD_W-1:0] keypad_wakeup_pins = '0;
  logic [DATA_W-1:0] rdata;
  int err_count = 0;
  int tests_run = 0;
  logic [7:0] msk [4] = '{8'hFF, 8'h7F, 8'h07, 8'h03};
  logic [7:0] ev [4] = '{8'h3C, 8'h4C, 8'h02, 8'h02};
  always #2 clk_sys_i = ~clk_sys_i;
  gph_ports u_dut (.clk_sys_i, .reset_n_i, .bus_i, .rdata_o(rdata), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .periph_e_i(pe), .timer_i(tm),
    .keypad_interrupt_enable_bits_i(keypad_wakeup_pins), .pin_level_o());
  gph_pin_far u_far (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_i(ext), .pin_o(pin_in));
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clk_sys_i);
    bus_i <= '{a, d, w, r};
  endtask : op
  // Read data stands one cycle only, so look just after the following edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    op(a, 8'h00, 1'b0, 1'b1);
    op(8'h00, 8'h00, 1'b0, 1'b0);
    #1 chk("rdata", {12'h000, exp}, {12'h000, rdata});
  endtask : rd
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    ext <= {ev[0], ev[1][6:0], ev[2][2:0], ev[3][1:0]};
    for (int i = 0; i < 4; i++) begin
      rd(8'(12 + i), 8'h00);
      op(8'(8 + i), 8'hA5, 1'b1, 1'b0);
      rd(8'(8 + i), ev[i] & msk[i]);
      op(8'(12 + i), 8'h0F, 1'b1, 1'b0);
      rd(8'(12 + i), 8'h0F & msk[i]);
      rd(8'(8 + i), (8'h05 | (ev[i] & 8'hF0)) & msk[i]);
    end
    chk("oe", {8'h0F, 7'h0F, 3'h7, 2'h3}, pin_oe);
    chk("out", {8'h05, 7'h05, 3'h5, 2'h1}, pin_out & pin_oe);
    $display("test read mux done");
    // Reset is asserted on an edge like every other input
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(12 + i), 8'h00);
      op(8'(12 + i), 8'hFF, 1'b1, 1'b0);
      rd(8'(8 + i), 8'hA5 & msk[i]);
    end
    $display("test latch keep done");
    @(posedge clk_sys_i);
    pe <= '{8'hFF, 8'h55, 8'h33};
    tm <= '{8'h55, 4'hA, 4'h5, 4'h5, 2'h2, 2'h1};
    keypad_wakeup_pins <= 5'h1F;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("oe", {8'h33, 7'h55, 3'h0, 2'h0}, pin_oe);
    chk("out", {5'h00, 8'h55, 7'h2A}, {5'h00, pin_out.e, pin_out.f});
    rd(8'h09, 8'h25);
    rd(8'h08, 8'hA5);
    $display("test override done");
    test_done();
  end
endmodule : tb_gph_ports_e_to_h
